/* File: logic/dsadc_defs.vh */
// constants for the dual-slope converter sequencer
`ifndef DSADC_DEFS_VH
`define DSADC_DEFS_VH
// ----------------------------------------------------------------
// timing: clock rates, phase lengths in pulses of the 100 kHz conversion clock, chopper divider as log2
// ----------------------------------------------------------------
`define DSADC_CONV_CLK_HZ    100000
`define DSADC_MCLK_HZ        125000000
`define DSADC_AZ_COUNTS      10000
`define DSADC_SI_COUNTS      10000
`define DSADC_RI_COUNTS      20000
`define DSADC_CHOP_DIV_LOG2  8
// ----------------------------------------------------------------
// phase one-hot codes
// ----------------------------------------------------------------
`define DSADC_ST_AZ          3'h1
`define DSADC_ST_SI          3'h2
`define DSADC_ST_RI          3'h4
// ----------------------------------------------------------------
// reading layout and range codes
// ----------------------------------------------------------------
`define DSADC_DIGITS         5
`define DSADC_DIGIT_W        4
`define DSADC_DEC_MAX        4'h9
`define DSADC_SCAN_COUNTS    5'h14
`define DSADC_OVR_BCD        20'h20000
`define DSADC_RANGE_TOP_I    3'h5
`endif

/* File: logic/dsadc_bcd_digit.v */
// one decade of the BCD reference-integrate counter
`timescale 1ns/10ps
module dsadc_bcd_digit
(
	mclk,
	resetn,
	clr,
	inc,
	digit,
	carry
);
`include "dsadc_defs.vh"
	input  wire       mclk;
	input  wire       resetn;
	input  wire       clr;
	input  wire       inc;
	output wire [3:0] digit;
	output wire       carry;

	reg [3:0] digit_q;

	// carry out while this decade wraps
	assign carry = inc & (digit_q == `DSADC_DEC_MAX);
	assign digit = digit_q;

	// clear wins over counting so each reading starts at zero
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			digit_q <= 4'h0;
		else if (clr)
			digit_q <= 4'h0;
		else if (carry)
			digit_q <= 4'h0;
		else if (inc)
			digit_q <= digit_q + 4'h1;
	end
endmodule

/* File: logic/dsadc_sequencer.v */
// dual-slope sequencer, chopper drive and multiplexed BCD reading
`timescale 1ns/10ps
// Behaviour
// - all phase lengths and counts are in pulses of the 100 kHz tick
// - chopper drive is the 100 kHz tick divided to about 390 Hz
// - chopper drive comes out as two complementary phases
// - demodulator drive is synchronous with the modulator drive
// - demodulator uses the very same phase as the second modulator switch
// - phases cycle auto-zero, signal-integrate, reference-integrate, repeat
// - auto-zero lasts 10000 pulses plus whatever is left of the reference window
// - signal-integrate lasts 10000 pulses, input connected
// - reference-integrate picks ground or double reference by polarity
// - count pulses from reference start to baseline, latch as reading
// - reference window is 20000 pulses at most, full scale
// - rest of window after baseline is spent in auto-zero
// - gain ten on every current range except top range, gain hundred
// - latched reading leaves as five BCD digits, one at a time
module dsadc_sequencer
#(
	parameter AZ_COUNTS = `DSADC_AZ_COUNTS,
	parameter SI_COUNTS = `DSADC_SI_COUNTS,
	parameter RI_COUNTS = `DSADC_RI_COUNTS
)
(
	mclk,
	resetn,
	conv_tick,
	comp_above,
	current_mode,
	range_sel,
	az_switch,
	si_switch,
	ref_ground,
	ref_double,
	modulator_switch_a,
	modulator_switch_b,
	demod_switch,
	gain_x10,
	gain_x100,
	reading_valid,
	overrange,
	polarity_neg,
	digit_bcd,
	digit_sel
);
`include "dsadc_defs.vh"
	input  wire        mclk;
	input  wire        resetn;
	input  wire        conv_tick;
	input  wire        comp_above;
	input  wire        current_mode;
	input  wire [2:0]  range_sel;
	output wire        az_switch;
	output wire        si_switch;
	output wire        ref_ground;
	output wire        ref_double;
	output wire        modulator_switch_a;
	output wire        modulator_switch_b;
	output wire        demod_switch;
	output wire        gain_x10;
	output wire        gain_x100;
	output wire        reading_valid;
	output wire        overrange;
	output wire        polarity_neg;
	output wire [3:0]  digit_bcd;
	output wire [4:0]  digit_sel;

	localparam ST_AZ = `DSADC_ST_AZ;
	localparam ST_SI = `DSADC_ST_SI;
	localparam ST_RI = `DSADC_ST_RI;
	localparam DIV_W = `DSADC_CHOP_DIV_LOG2;

	// ----------------------------------------------------------------
	// state and counters
	// ----------------------------------------------------------------
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg  [14:0] phase_cnt_q;
	reg  [14:0] phase_cnt_d;
	reg  [14:0] extra_len_q;
	reg  [14:0] extra_len_d;
	reg         pol_q;
	reg         baseline_q;
	reg  [DIV_W-1:0] chop_div_q;
	reg  [19:0] latch_q;
	reg         over_q;
	reg         valid_q;
	reg         latch_pol_q;
	reg  [4:0]  scan_cnt_q;
	reg  [4:0]  sel_q;
	reg  [3:0]  bcd_q;
	reg         mod_a_q;
	reg         mod_b_q;
	reg         gx10_q;
	reg         gx100_q;
	wire [19:0] count_bcd;
	wire [4:0]  carries;
	wire        cnt_clr;
	wire        cnt_inc;
	wire        ri_end;
	wire        baseline_hit;

	// ----------------------------------------------------------------
	// chopper divider
	// ----------------------------------------------------------------
	// binary 256 divider runs off the same tick as the sequencer,
	// so chopper edges fall on sequencer ticks; it is never restarted, so its phase drifts against the 40000-pulse frame
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			chop_div_q <= {DIV_W{1'b0}};
		else if (conv_tick)
			chop_div_q <= chop_div_q + {{(DIV_W-1){1'b0}}, 1'b1};
	end

	// two opposite phases from flops; demod follows phase b
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			mod_a_q <= 1'b0;
			mod_b_q <= 1'b1;
		end
		else
		begin
			mod_a_q <= chop_div_q[DIV_W-1];
			mod_b_q <= ~chop_div_q[DIV_W-1];
		end
	end

	assign modulator_switch_a = mod_a_q;
	assign modulator_switch_b = mod_b_q;
	assign demod_switch       = mod_b_q;

	// ----------------------------------------------------------------
	// phase sequencer
	// ----------------------------------------------------------------
	assign baseline_hit = (state_q == ST_RI) & conv_tick & ~baseline_q &
		(comp_above != pol_q);
	assign ri_end = (state_q == ST_RI) & conv_tick &
		(baseline_hit | (phase_cnt_q == RI_COUNTS[14:0] - 15'h1));

	// next state; leftover window time is added to the next auto-zero
	always @*
	begin
		state_d     = state_q;
		phase_cnt_d = phase_cnt_q;
		extra_len_d = extra_len_q;
		if (conv_tick)
		begin
			phase_cnt_d = phase_cnt_q + 15'h1;
			case (state_q)
			ST_AZ:
				if (phase_cnt_q == AZ_COUNTS[14:0] + extra_len_q
					- 15'h1)
				begin
					state_d     = ST_SI;
					phase_cnt_d = 15'h0;
					extra_len_d = 15'h0;
				end
			ST_SI:
				if (phase_cnt_q == SI_COUNTS[14:0] - 15'h1)
				begin
					state_d     = ST_RI;
					phase_cnt_d = 15'h0;
				end
			ST_RI:
				if (ri_end)
				begin
					state_d     = ST_AZ;
					phase_cnt_d = 15'h0;
					extra_len_d = RI_COUNTS[14:0] - phase_cnt_q
						- 15'h1;
				end
			default:
			begin
				state_d     = ST_AZ;
				phase_cnt_d = 15'h0;
			end
			endcase
		end
	end

	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q     <= ST_AZ;
			phase_cnt_q <= 15'h0;
			extra_len_q <= 15'h0;
		end
		else
		begin
			state_q     <= state_d;
			phase_cnt_q <= phase_cnt_d;
			extra_len_q <= extra_len_d;
		end
	end

	// polarity caught on the last integrate tick; baseline flag per window
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pol_q      <= 1'b0;
			baseline_q <= 1'b0;
		end
		else
		begin
			if ((state_q == ST_SI) & conv_tick &
				(phase_cnt_q == SI_COUNTS[14:0] - 15'h1))
			begin
				pol_q      <= comp_above;
				baseline_q <= 1'b0;
			end
			else if (baseline_hit)
				baseline_q <= 1'b1;
		end
	end

	// switch drives decode straight from state and polarity flops
	assign az_switch  = (state_q == ST_AZ);
	assign si_switch  = (state_q == ST_SI);
	assign ref_ground = (state_q == ST_RI) & ~pol_q;
	assign ref_double = (state_q == ST_RI) & pol_q;

	// ----------------------------------------------------------------
	// reading counter and latch
	// ----------------------------------------------------------------
	assign cnt_clr = (state_q == ST_SI);
	assign cnt_inc = (state_q == ST_RI) & conv_tick & ~baseline_hit;

	genvar gi;
	generate
		for (gi = 0; gi < `DSADC_DIGITS; gi = gi + 1)
		begin : g_dec
			wire inc_i;
			if (gi == 0)
				assign inc_i = cnt_inc;
			else
				assign inc_i = carries[gi-1];
			dsadc_bcd_digit u_dig
			(
				.mclk   (mclk),
				.resetn (resetn),
				.clr    (cnt_clr),
				.inc    (inc_i),
				.digit  (count_bcd[gi*4+3:gi*4]),
				.carry  (carries[gi])
			);
		end
	endgenerate

	// latch on baseline or at the window limit (overrange)
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			latch_q     <= 20'h0;
			over_q      <= 1'b0;
			valid_q     <= 1'b0;
			latch_pol_q <= 1'b0;
		end
		else if (ri_end)
		begin
			latch_q     <= baseline_hit ? count_bcd : `DSADC_OVR_BCD;
			over_q      <= ~baseline_hit;
			valid_q     <= 1'b1;
			latch_pol_q <= pol_q;
		end
	end

	assign reading_valid = valid_q;
	assign overrange     = over_q;
	assign polarity_neg  = latch_pol_q;

	// ----------------------------------------------------------------
	// digit multiplex
	// ----------------------------------------------------------------
	// each digit held for a fixed number of ticks, most significant first
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			scan_cnt_q <= 5'h0;
			sel_q      <= 5'h10;
		end
		else if (conv_tick)
		begin
			if (scan_cnt_q == `DSADC_SCAN_COUNTS - 5'h1)
			begin
				scan_cnt_q <= 5'h0;
				sel_q      <= {sel_q[0], sel_q[4:1]};
			end
			else
				scan_cnt_q <= scan_cnt_q + 5'h1;
		end
	end

	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			bcd_q <= 4'h0;
		else if (sel_q[4])
			bcd_q <= latch_q[19:16];
		else if (sel_q[3])
			bcd_q <= latch_q[15:12];
		else if (sel_q[2])
			bcd_q <= latch_q[11:8];
		else if (sel_q[1])
			bcd_q <= latch_q[7:4];
		else
			bcd_q <= latch_q[3:0];
	end

	assign digit_bcd = bcd_q;
	assign digit_sel = sel_q;

	// ----------------------------------------------------------------
	// chopper gain for current ranges
	// ----------------------------------------------------------------
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			gx10_q  <= 1'b0;
			gx100_q <= 1'b0;
		end
		else
		begin
			gx100_q <= current_mode & (range_sel == `DSADC_RANGE_TOP_I);
			gx10_q  <= current_mode & (range_sel != `DSADC_RANGE_TOP_I);
		end
	end

	assign gain_x10  = gx10_q;
	assign gain_x100 = gx100_q;
endmodule

/* File: tb/dsadc_chk.sv */
// port checker for the converter sequencer
`timescale 1ns/10ps
`include "dsadc_defs.vh"
module dsadc_chk
#(
	parameter AZ_COUNTS = 10,
	parameter SI_COUNTS = 10,
	parameter RI_COUNTS = 20
)
(
	input wire       mclk,
	input wire       resetn,
	input wire       conv_tick,
	input wire       comp_above,
	input wire       current_mode,
	input wire [2:0] range_sel,
	input wire       az_switch,
	input wire       si_switch,
	input wire       ref_ground,
	input wire       ref_double,
	input wire       modulator_switch_a,
	input wire       modulator_switch_b,
	input wire       demod_switch,
	input wire       gain_x10,
	input wire       gain_x100,
	input wire [4:0] digit_sel
);
	wire [7:0] tk = {7'h0, conv_tick};
	wire       ri = ref_ground | ref_double;
	wire       top = current_mode & (range_sel == `DSADC_RANGE_TOP_I);
	reg  [7:0] chop_q;
	reg  [7:0] cyc_q;
	reg  [7:0] si_q;
	reg        seen_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// tick counts; the first cycle after reset has no leftover, so skip it
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			chop_q <= 8'h0;
			cyc_q <= 8'h0;
			si_q <= 8'h0;
			seen_q <= 1'b0;
		end
		else
		begin
			chop_q <= $changed(modulator_switch_a) ? tk : chop_q + tk;
			cyc_q <= $rose(si_switch) ? tk : cyc_q + tk;
			si_q <= si_switch ? si_q + tk : 8'h0;
			seen_q <= seen_q | $rose(si_switch);
		end
	end
	property p_pair; modulator_switch_a != modulator_switch_b; endproperty
	a_pair: assert property (p_pair) else $error("chop phases");
	property p_demod; demod_switch == modulator_switch_b; endproperty
	a_demod: assert property (p_demod) else $error("demod drive");
	property p_half;
		$changed(modulator_switch_a) |-> chop_q == 8'd128;
	endproperty
	a_half: assert property (p_half) else $error("chop rate");
	property p_phase; $onehot({az_switch, si_switch, ri}); endproperty
	a_phase: assert property (p_phase) else $error("phase code");
	property p_si; $rose(si_switch) |-> $past(az_switch); endproperty
	a_si: assert property (p_si) else $error("phase order");
	property p_ri;
		$rose(ri) |-> $past(si_switch & conv_tick)
			&& ref_double == $past(comp_above);
	endproperty
	a_ri: assert property (p_ri) else $error("reference pick");
	property p_cyc;
		$rose(si_switch) && seen_q |->
			cyc_q == AZ_COUNTS + SI_COUNTS + RI_COUNTS;
	endproperty
	a_cyc: assert property (p_cyc) else $error("cycle length");
	property p_si_len; $fell(si_switch) |-> si_q == SI_COUNTS; endproperty
	a_si_len: assert property (p_si_len) else $error("integrate len");
	property p_gain;
		resetn |=> gain_x100 == $past(top)
			&& gain_x10 == $past(current_mode & ~top);
	endproperty
	a_gain: assert property (p_gain) else $error("gain select");
	property p_scan; $onehot(digit_sel); endproperty
	a_scan: assert property (p_scan) else $error("digit scan");
endmodule
bind dsadc_sequencer dsadc_chk #(.AZ_COUNTS(AZ_COUNTS),
	.SI_COUNTS(SI_COUNTS), .RI_COUNTS(RI_COUNTS)) u_dsadc_chk (
	.mclk(mclk), .resetn(resetn), .conv_tick(conv_tick),
	.comp_above(comp_above), .current_mode(current_mode),
	.range_sel(range_sel), .az_switch(az_switch), .si_switch(si_switch),
	.ref_ground(ref_ground), .ref_double(ref_double),
	.modulator_switch_a(modulator_switch_a),
	.modulator_switch_b(modulator_switch_b),
	.demod_switch(demod_switch), .gain_x10(gain_x10),
	.gain_x100(gain_x100), .digit_sel(digit_sel));

/* File: tb/dsadc_integ_model.sv */
// analog side: integrator ramps and baseline comparator
`timescale 1ns/10ps
module dsadc_integ_model
(
	input  wire              mclk,
	input  wire              conv_tick,
	input  wire              az_switch,
	input  wire              si_switch,
	input  wire              ref_ground,
	input  wire              ref_double,
	input  wire signed [7:0] slope,
	output wire              comp_above
);
	reg signed [15:0] integ_q = 16'sh0;
	// zero counts as reached when rising, so both signs give equal counts
	assign comp_above = ref_ground ? integ_q >= 0 : integ_q > 0;
	// one charge step per conversion tick
	always @(posedge mclk)
	begin
		if (conv_tick & az_switch)
			integ_q <= 16'sh0;
		if (conv_tick & si_switch)
			integ_q <= integ_q + slope;
		if (conv_tick & ref_double)
			integ_q <= integ_q - 16'sh1;
		if (conv_tick & ref_ground)
			integ_q <= integ_q + 16'sh1;
	end
endmodule

/* File: tb/dsadc_sequencer_tb.sv */
// bench for the converter sequencer
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("FAIL %0t mismatch", $time); end end
module dsadc_sequencer_tb;
	reg         mclk = 1'b0;
	reg         resetn = 1'b0;
	reg         tick = 1'b0;
	reg         cmode = 1'b0;
	reg         chk = 1'b0;
	reg  [2:0]  rsel = 3'h0;
	reg  [1:0]  tdiv = 2'h0;
	reg  [31:0] lf = 32'h20;
	reg  [7:0]  slope = 8'h0;
	reg  [4:0]  psel = 5'h0;
	reg  [3:0]  dig [0:4];
	reg  [21:0] expq [$];
	wire        comp, az, si, rg, rd, ma, mb, dm, rv, ovr, pn;
	wire [3:0]  dbcd;
	wire [4:0]  dsel;
	int         fails = 0;
	int         n_tests = 0;
	int         cyc = 0;
	dsadc_sequencer #(.AZ_COUNTS(10), .SI_COUNTS(10), .RI_COUNTS(20))
	u_dsadc_sequencer (.mclk(mclk), .resetn(resetn), .conv_tick(tick),
		.comp_above(comp), .current_mode(cmode), .range_sel(rsel),
		.az_switch(az), .si_switch(si), .ref_ground(rg), .ref_double(rd),
		.modulator_switch_a(ma), .modulator_switch_b(mb),
		.demod_switch(dm), .gain_x10(), .gain_x100(), .reading_valid(rv),
		.overrange(ovr), .polarity_neg(pn), .digit_bcd(dbcd),
		.digit_sel(dsel));
	dsadc_integ_model u_dsadc_integ_model (.mclk(mclk), .conv_tick(tick),
		.az_switch(az), .si_switch(si), .ref_ground(rg), .ref_double(rd),
		.slope(slope), .comp_above(comp));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task tally_and_finish;
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// five conversions: later ones repeat the count over a whole scan
	task run_case(input int s);
		int r;
		r = (s < 0 ? -s : s) * 10;
		slope <= s[7:0];
		repeat (5) @(posedge az);
		@(posedge mclk);
		// a cut window latches the fixed full-scale reading
		if (r > 19)
			expq.push_back({s > 0, 1'b1, 20'h20000});
		else
			expq.push_back({s > 0, 1'b0, 12'h0, 4'(r / 10), 4'h0});
		chk <= 1'b1;
		@(posedge mclk);
		chk <= 1'b0;
	endtask
	initial
	begin
		forever #4 mclk = ~mclk;
	end
	// tick every fourth cycle, random range; hang guard
	always @(posedge mclk)
	begin
		tdiv <= tdiv + 2'h1;
		tick <= (tdiv == 2'h3);
		lf <= lfsr(lf);
		rsel <= lf[2:0];
		cmode <= lf[3];
		cyc <= cyc + 1;
		if (cyc == 12000)
		begin
			fails++;
			tally_and_finish;
		end
	end
	// digit capture lags select by one cycle; check takes the oldest note
	always @(posedge mclk)
	begin
		psel <= dsel;
		for (int i = 0; i < 5; i++)
			if (psel[i])
				dig[i] <= dbcd;
		if (chk)
		begin
			`CHK({dig[4], dig[3], dig[2], dig[1], dig[0]}, expq[0][19:0])
			`CHK({pn, ovr}, expq[0][21:20])
			`CHK(rv, 1'b1)
			void'(expq.pop_front());
		end
	end
	// signs and magnitudes up to overrange, then a mid-run reset
	initial
	begin
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		for (int s = -2; s < 3; s++)
			run_case(s);
		resetn <= 1'b0;
		@(posedge mclk);
		#1;
		`CHK({az, ma, mb, dm, dsel}, {4'hb, 5'h10})
		`CHK({rv, ovr, pn, dbcd}, 7'h0)
		@(posedge mclk);
		resetn <= 1'b1;
		run_case(1);
		tally_and_finish;
	end
endmodule
